// [hdl/adc_select_ctrl.sv]
// selection register, deferred settings, result registers and APB access for the converter
//
// Design decisions made here: the address map and the APB register port.
module adc_select_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    output logic conv_start,
    input wire logic conv_done,
    input wire logic [9:0] conv_data,
    output logic [1:0] reference_select,
    output logic internal_ref_on,
    output adc_select_pkg::channel_route_t route,
    output logic conversion_done_flag,
    output logic busy
);

    logic [7:0] select_r;
    logic [7:0] select_nxt;
    logic [1:0] active_ref_r;
    logic [1:0] active_ref_nxt;
    logic [4:0] active_mux_r;
    logic [4:0] active_mux_nxt;
    logic [9:0] result_r;
    logic [9:0] result_nxt;
    logic result_diff_r;
    logic result_diff_nxt;
    logic lock_r;
    logic lock_nxt;
    logic done_r;
    logic done_nxt;
    logic start_r;
    logic start_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic err_r;
    logic err_nxt;
    adc_select_pkg::conv_state_t state_r;
    adc_select_pkg::conv_state_t state_nxt;
    logic setup;
    logic access;
    logic wr;
    logic rd;
    logic mapped;
    logic start_req;
    logic complete;
    logic high_read;
    logic low_read;
    logic [7:0] high_byte;
    logic [7:0] low_byte;
    logic left_adjust_result;

    assign left_adjust_result = select_r[adc_select_pkg::LEFT_ADJ_BIT];

    // bus phase decode; slave answers in the first access cycle
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr = access && pwrite;
    assign rd = access && !pwrite;
    assign pready = 1'b1;
    assign mapped = (paddr == adc_select_pkg::ADDR_SELECT) || (paddr == adc_select_pkg::ADDR_RES_LOW)
        || (paddr == adc_select_pkg::ADDR_RES_HIGH) || (paddr == adc_select_pkg::ADDR_CTRL);
    // low byte is captured at setup, so the freeze starts there too and no result slips in before access
    assign low_read = setup && !pwrite && (paddr == adc_select_pkg::ADDR_RES_LOW);
    assign high_read = rd && (paddr == adc_select_pkg::ADDR_RES_HIGH);
    assign start_req = wr && (paddr == adc_select_pkg::ADDR_CTRL) && pwdata[adc_select_pkg::CTRL_START_BIT]
        && (state_r == adc_select_pkg::ST_IDLE);
    assign complete = (state_r == adc_select_pkg::ST_CONVERT) && conv_done;

    // result byte layout follows the live left adjust bit
    result_format u_format (
        .result(result_r),
        .left_adjust_result(left_adjust_result),
        .result_high_byte(high_byte),
        .result_low_byte(low_byte)
    );

    // routing uses the settings latched at start, not the live register
    channel_decode u_decode (
        .input_channel_select(active_mux_r),
        .route(route)
    );

    // conversion sequencing and deferred settings
    always_comb begin
        state_nxt = state_r;
        active_ref_nxt = active_ref_r;
        active_mux_nxt = active_mux_r;
        start_nxt = 1'b0;
        case (state_r)
            adc_select_pkg::ST_IDLE: begin
                if (start_req) begin
                    active_ref_nxt = select_r[adc_select_pkg::REF_MSB:adc_select_pkg::REF_LSB];
                    active_mux_nxt = select_r[adc_select_pkg::MUX_MSB:adc_select_pkg::MUX_LSB];
                    start_nxt = 1'b1;
                    state_nxt = adc_select_pkg::ST_CONVERT;
                end
            end
            adc_select_pkg::ST_CONVERT: begin
                if (conv_done) begin
                    state_nxt = adc_select_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = adc_select_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= adc_select_pkg::ST_IDLE;
            active_ref_r <= adc_select_pkg::REF_EXTERNAL;
            active_mux_r <= 5'h00;
            start_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            active_ref_r <= active_ref_nxt;
            active_mux_r <= active_mux_nxt;
            start_r <= start_nxt;
        end
    end

    // selection register, result capture, read lock and done flag
    always_comb begin
        select_nxt = select_r;
        result_nxt = result_r;
        result_diff_nxt = result_diff_r;
        lock_nxt = lock_r;
        done_nxt = done_r;
        if (wr && (paddr == adc_select_pkg::ADDR_SELECT)) begin
            select_nxt = pwdata[7:0];
        end
        if (low_read) begin
            lock_nxt = 1'b1;
        end
        if (high_read) begin
            lock_nxt = 1'b0;
        end
        if (wr && (paddr == adc_select_pkg::ADDR_CTRL) && pwdata[adc_select_pkg::CTRL_DONE_BIT]) begin
            done_nxt = 1'b0;
        end
        // a completion that lands while frozen is discarded; set beats clear
        if (complete && ((!lock_r && !low_read) || high_read)) begin
            result_nxt = conv_data;
            result_diff_nxt = route.differential;
            done_nxt = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            select_r <= adc_select_pkg::SELECT_RESET;
            result_r <= 10'h000;
            result_diff_r <= 1'b0;
            lock_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            select_r <= select_nxt;
            result_r <= result_nxt;
            result_diff_r <= result_diff_nxt;
            lock_r <= lock_nxt;
            done_r <= done_nxt;
        end
    end

    // read data and error captured in the setup cycle
    always_comb begin
        prdata_nxt = prdata_r;
        err_nxt = err_r;
        if (setup) begin
            prdata_nxt = 32'h0000_0000;
            err_nxt = !mapped;
            case (paddr)
                adc_select_pkg::ADDR_SELECT: begin
                    prdata_nxt[7:0] = select_r;
                end
                adc_select_pkg::ADDR_RES_LOW: begin
                    prdata_nxt[7:0] = low_byte;
                end
                adc_select_pkg::ADDR_RES_HIGH: begin
                    prdata_nxt[7:0] = high_byte;
                end
                adc_select_pkg::ADDR_CTRL: begin
                    prdata_nxt[adc_select_pkg::CTRL_START_BIT] = (state_r == adc_select_pkg::ST_CONVERT);
                    prdata_nxt[adc_select_pkg::CTRL_DONE_BIT] = done_r;
                    prdata_nxt[adc_select_pkg::CTRL_SIGN_BIT] = result_diff_r && result_r[9];
                    prdata_nxt[adc_select_pkg::CTRL_DIFF_BIT] = result_diff_r;
                    prdata_nxt[adc_select_pkg::CTRL_LOCK_BIT] = lock_r;
                end
                default: begin
                    prdata_nxt = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
            err_r <= 1'b0;
        end else begin
            prdata_r <= prdata_nxt;
            err_r <= err_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pslverr = err_r && access;
    assign conv_start = start_r;
    assign busy = (state_r == adc_select_pkg::ST_CONVERT);
    assign conversion_done_flag = done_r;
    assign reference_select = active_ref_r;
    assign internal_ref_on = (active_ref_r == adc_select_pkg::REF_INTERNAL);

    // checks
    result_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
        complete && !lock_r && !low_read |=> result_r == $past(conv_data))
        else $error("result not captured at completion");

    done_flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        complete && !lock_r && !low_read |=> conversion_done_flag && !busy)
        else $error("done flag not set at completion");

    result_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
        lock_r && !high_read |=> $stable(result_r))
        else $error("result changed while frozen");

    settings_held_a: assert property (@(posedge pclk) disable iff (!presetn)
        busy |=> $stable(active_ref_r) && $stable(active_mux_r))
        else $error("settings changed during conversion");

    start_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
        start_req |=> conv_start && active_mux_r == $past(select_r[4:0]) && reference_select == $past(select_r[7:6]))
        else $error("settings not latched at start");

    left_layout_a: assert property (@(posedge pclk) disable iff (!presetn)
        left_adjust_result |-> high_byte == result_r[9:2] && low_byte[7:6] == result_r[1:0])
        else $error("left layout wrong");

    right_sign_a: assert property (@(posedge pclk) disable iff (!presetn)
        !left_adjust_result |-> high_byte[1] == result_r[9] && low_byte == result_r[7:0])
        else $error("right layout or sign position wrong");

    single_channel_a: assert property (@(posedge pclk) disable iff (!presetn)
        active_mux_r < adc_select_pkg::MUX_DIFF_GAIN |-> !route.differential && route.positive == active_mux_r[2:0])
        else $error("single-ended channel decode wrong");

    gain_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
        active_mux_r == 5'h0B |-> route.gain == adc_select_pkg::GAIN_200X && route.positive == 3'h1)
        else $error("gained pair decode wrong");

    internal_source_a: assert property (@(posedge pclk) disable iff (!presetn)
        active_mux_r == adc_select_pkg::MUX_GROUND |-> route.source == adc_select_pkg::SRC_GROUND)
        else $error("ground source decode wrong");

    adjust_immediate_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(left_adjust_result) && $stable(result_r) |-> high_byte == result_r[9:2])
        else $error("left adjust not applied at once");

    internal_ref_a: assert property (@(posedge pclk) disable iff (!presetn)
        internal_ref_on |-> reference_select == 2'h3)
        else $error("internal reference enable wrong");

    low_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
        low_read |=> lock_r && $stable(result_r))
        else $error("result moved between low byte capture and freeze");

    done_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr && (paddr == adc_select_pkg::ADDR_CTRL) && pwdata[adc_select_pkg::CTRL_DONE_BIT] && !complete
        |=> !conversion_done_flag)
        else $error("done flag not cleared by write");

    start_refused_a: assert property (@(posedge pclk) disable iff (!presetn)
        busy |=> !conv_start && $stable(reference_select))
        else $error("start accepted during a conversion");

    sign_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        setup && (paddr == adc_select_pkg::ADDR_CTRL)
        |=> prdata[adc_select_pkg::CTRL_SIGN_BIT] == $past(result_diff_r && result_r[9]))
        else $error("sign bit read wrong");

endmodule : adc_select_ctrl

// [hdl/adc_select_pkg.sv]
// shared constants and types for the converter selection and result formatting block
package adc_select_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int RES_W = 10;
    localparam int BYTE_W = 8;

    // register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_SELECT = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RES_LOW = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_RES_HIGH = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h0C;

    // selection register fields
    localparam int REF_MSB = 7;
    localparam int REF_LSB = 6;
    localparam int LEFT_ADJ_BIT = 5;
    localparam int MUX_MSB = 4;
    localparam int MUX_LSB = 0;
    localparam logic [BYTE_W-1:0] SELECT_RESET = 8'h00;

    // control/status register fields
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_DONE_BIT = 1;
    localparam int CTRL_SIGN_BIT = 2;
    localparam int CTRL_DIFF_BIT = 3;
    localparam int CTRL_LOCK_BIT = 4;

    // reference codes
    localparam logic [1:0] REF_EXTERNAL = 2'h0;
    localparam logic [1:0] REF_SUPPLY = 2'h1;
    localparam logic [1:0] REF_RESERVED = 2'h2;
    localparam logic [1:0] REF_INTERNAL = 2'h3;

    // channel code boundaries
    localparam logic [4:0] MUX_DIFF_GAIN = 5'h08;
    localparam logic [4:0] MUX_NEG_ONE = 5'h10;
    localparam logic [4:0] MUX_NEG_TWO = 5'h18;
    localparam logic [4:0] MUX_BANDGAP = 5'h1E;
    localparam logic [4:0] MUX_GROUND = 5'h1F;
    localparam logic [2:0] PAIR_LOW = 3'h0;
    localparam logic [2:0] PAIR_HIGH = 3'h2;
    localparam logic [2:0] NEG_ONE = 3'h1;
    localparam logic [2:0] NEG_TWO = 3'h2;

    typedef enum logic [1:0] {GAIN_1X, GAIN_10X, GAIN_200X} gain_t;
    typedef enum logic [1:0] {SRC_PIN, SRC_BANDGAP, SRC_GROUND} source_t;

    // analog routing derived from the channel code
    typedef struct packed {
        logic differential;
        source_t source;
        logic [2:0] positive;
        logic [2:0] negative;
        gain_t gain;
    } channel_route_t;

    typedef enum {ST_IDLE, ST_CONVERT} conv_state_t;

endpackage : adc_select_pkg

// [hdl/channel_decode.sv]
// decodes the five-bit channel code into analog routing
module channel_decode (
    input wire logic [4:0] input_channel_select,
    output adc_select_pkg::channel_route_t route
);

    // code groups: single pins, gained pairs, unity pairs, internal sources
    always_comb begin
        route.differential = 1'b0;
        route.source = adc_select_pkg::SRC_PIN;
        route.positive = input_channel_select[2:0];
        route.negative = input_channel_select[2:0];
        route.gain = adc_select_pkg::GAIN_1X;
        if (input_channel_select == adc_select_pkg::MUX_BANDGAP) begin
            route.source = adc_select_pkg::SRC_BANDGAP;
        end else if (input_channel_select == adc_select_pkg::MUX_GROUND) begin
            route.source = adc_select_pkg::SRC_GROUND;
        end else if (input_channel_select >= adc_select_pkg::MUX_NEG_TWO) begin
            route.differential = 1'b1;
            route.negative = adc_select_pkg::NEG_TWO;
        end else if (input_channel_select >= adc_select_pkg::MUX_NEG_ONE) begin
            route.differential = 1'b1;
            route.negative = adc_select_pkg::NEG_ONE;
        end else if (input_channel_select >= adc_select_pkg::MUX_DIFF_GAIN) begin
            route.differential = 1'b1;
            route.negative = input_channel_select[2] ? adc_select_pkg::PAIR_HIGH : adc_select_pkg::PAIR_LOW;
            route.positive = route.negative | {2'h0, input_channel_select[0]};
            route.gain = input_channel_select[1] ? adc_select_pkg::GAIN_200X : adc_select_pkg::GAIN_10X;
        end
    end

endmodule : channel_decode

// [hdl/result_format.sv]
// places the 10-bit result into the two result bytes
module result_format (
    input wire logic [9:0] result,
    input wire logic left_adjust_result,
    output logic [7:0] result_high_byte,
    output logic [7:0] result_low_byte
);

    // left: bits 9..2 high, 1..0 at top of low; right: 9..8 at bottom of high
    always_comb begin
        if (left_adjust_result) begin
            result_high_byte = result[9:2];
            result_low_byte = {result[1:0], 6'h00};
        end else begin
            result_high_byte = {6'h00, result[9:8]};
            result_low_byte = result[7:0];
        end
    end

endmodule : result_format

// [sim/adc_mux_result_format_tb_top.sv]
// self-checking bench for the converter selection and result formatting block
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; $display("BAD %s expected %0h seen %0h", nm, (e), (g)); end end
module adc_mux_result_format_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0;
    logic presetn;
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic conv_start;
    logic conv_done;
    logic [9:0] conv_data;
    logic [1:0] reference_select;
    logic internal_ref_on;
    adc_select_pkg::channel_route_t route;
    adc_select_pkg::channel_route_t er;
    logic conversion_done_flag;
    logic busy;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic err;
    logic [9:0] d;
    logic diff;
    logic [4:0] code;
    logic [7:0] sel_tab [4] = '{8'h00, 8'h40, 8'h0D, 8'hDB};
    logic [9:0] dat_tab [4] = '{10'h3FF, 10'h000, 10'h270, 10'h029};

    adc_select_ctrl adc_select_ctrl_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .conv_start(conv_start), .conv_done(conv_done), .conv_data(conv_data),
        .reference_select(reference_select), .internal_ref_on(internal_ref_on), .route(route),
        .conversion_done_flag(conversion_done_flag), .busy(busy));

    // free-running clock, 50 ns period
    always #25 pclk = ~pclk;

    // hang guard
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 8000) begin
            mismatches++;
            $display("timeout after %0d cycles", cycles);
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    // one apb transfer: setup, access held until pready is seen high
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0);
        `CHK(nm, e, rd)
    endtask : rd_chk

    // request a start and wait for busy
    task automatic start_conv();
        int n;
        apb(adc_select_pkg::ADDR_CTRL, 1'b1, 32'h1);
        n = 0;
        while (busy !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        `CHK("start pulse", 1'b1, conv_start)
    endtask : start_conv

    // converter answers with one done pulse, then the data line no longer holds the code
    task automatic finish_conv(input logic [9:0] v);
        int n;
        @(posedge pclk);
        conv_done <= 1'b1;
        conv_data <= v;
        @(posedge pclk);
        conv_done <= 1'b0;
        conv_data <= ~v;
        n = 0;
        while (busy !== 1'b0 && n < 20) begin
            @(posedge pclk);
            n++;
        end
    endtask : finish_conv

    // expected analog routing of a channel code
    function automatic adc_select_pkg::channel_route_t exp_route(input logic [4:0] c);
        adc_select_pkg::channel_route_t r;
        r = '0;
        r.source = adc_select_pkg::SRC_PIN;
        r.gain = adc_select_pkg::GAIN_1X;
        if (c < 5'h08) begin
            r.positive = c[2:0];
        end else if (c < 5'h10) begin
            r.differential = 1'b1;
            r.negative = c[2] ? 3'h2 : 3'h0;
            r.positive = r.negative | {2'h0, c[0]};
            r.gain = c[1] ? adc_select_pkg::GAIN_200X : adc_select_pkg::GAIN_10X;
        end else if (c < 5'h1E) begin
            r.differential = 1'b1;
            r.negative = c[3] ? 3'h2 : 3'h1;
            r.positive = c[2:0];
        end else begin
            r.source = c[0] ? adc_select_pkg::SRC_GROUND : adc_select_pkg::SRC_BANDGAP;
        end
        return r;
    endfunction : exp_route

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        conv_done = 1'b0;
        conv_data = 10'h000;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("select reset", adc_select_pkg::ADDR_SELECT, 32'h0);
        apb(8'h10, 1'b0, 32'h0);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h0, rd)
        $display("reset test done");
        // result formats, right then left adjusted, flag cleared before each conversion
        for (int i = 0; i < 4; i++) begin
            d = dat_tab[i];
            diff = sel_tab[i][3] | sel_tab[i][4];
            apb(adc_select_pkg::ADDR_CTRL, 1'b1, 32'h2);
            apb(adc_select_pkg::ADDR_SELECT, 1'b1, {24'h0, sel_tab[i]});
            start_conv();
            finish_conv(d);
            `CHK("done pin", 1'b1, conversion_done_flag)
            rd_chk("right low", adc_select_pkg::ADDR_RES_LOW, {24'h0, d[7:0]});
            rd_chk("right high", adc_select_pkg::ADDR_RES_HIGH, {30'h0, d[9:8]});
            rd_chk("ctrl", adc_select_pkg::ADDR_CTRL, {28'h0, diff, diff & d[9], 2'h2});
            apb(adc_select_pkg::ADDR_SELECT, 1'b1, {24'h0, sel_tab[i] | 8'h20});
            rd_chk("left low", adc_select_pkg::ADDR_RES_LOW, {24'h0, d[1:0], 6'h0});
            rd_chk("left high", adc_select_pkg::ADDR_RES_HIGH, {24'h0, d[9:2]});
        end
        apb(adc_select_pkg::ADDR_RES_LOW, 1'b1, 32'hAA);
        rd_chk("low read only", adc_select_pkg::ADDR_RES_LOW, 32'h40);
        $display("format test done");
        // settings written mid-conversion wait for the next start
        apb(adc_select_pkg::ADDR_SELECT, 1'b1, 32'h43);
        start_conv();
        apb(adc_select_pkg::ADDR_SELECT, 1'b1, 32'hE5);
        `CHK("ref held", 2'h1, reference_select)
        `CHK("chan held", 3'h3, route.positive)
        rd_chk("left in flight", adc_select_pkg::ADDR_RES_HIGH, 32'h0A);
        finish_conv(10'h1FF);
        `CHK("ref after done", 2'h1, reference_select)
        start_conv();
        `CHK("ref new", 2'h3, reference_select)
        `CHK("chan new", 3'h5, route.positive)
        `CHK("int ref on", 1'b1, internal_ref_on)
        finish_conv(10'h000);
        $display("deferred test done");
        // low byte read freezes the pair until the high byte is read
        apb(adc_select_pkg::ADDR_SELECT, 1'b1, 32'h00);
        start_conv();
        finish_conv(10'h155);
        apb(adc_select_pkg::ADDR_CTRL, 1'b1, 32'h2);
        rd_chk("frozen low", adc_select_pkg::ADDR_RES_LOW, 32'h55);
        start_conv();
        finish_conv(10'h2AA);
        `CHK("frozen pin", 1'b0, conversion_done_flag)
        rd_chk("frozen ctrl", adc_select_pkg::ADDR_CTRL, 32'h10);
        rd_chk("frozen high", adc_select_pkg::ADDR_RES_HIGH, 32'h01);
        rd_chk("after release", adc_select_pkg::ADDR_RES_LOW, 32'h55);
        rd_chk("pair high", adc_select_pkg::ADDR_RES_HIGH, 32'h01);
        $display("freeze test done");
        // every channel code, reference cycling with the low code bits
        for (int c = 0; c < 32; c++) begin
            code = 5'(c);
            er = exp_route(code);
            apb(adc_select_pkg::ADDR_SELECT, 1'b1, {24'h0, code[1:0], 1'b0, code});
            start_conv();
            `CHK("diff", er.differential, route.differential)
            `CHK("source", er.source, route.source)
            `CHK("gain", er.gain, route.gain)
            if (er.source == adc_select_pkg::SRC_PIN) `CHK("pos", er.positive, route.positive)
            if (er.differential) `CHK("neg", er.negative, route.negative)
            `CHK("ref", code[1:0], reference_select)
            `CHK("int ref", code[1:0] == 2'h3, internal_ref_on)
            finish_conv(10'h000);
        end
        $display("channel test done");
        tally_and_finish();
    end
endmodule : adc_mux_result_format_tb_top
